/* File: hfc_pkg.sv */
// Purpose: Shared constants of the half float converter.
// Assumes: 32-bit AXI4-Lite register bus.
// Notes:   Flag vectors are ordered invalid, denormal, underflow, overflow, precision.
package hfc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] HFC_OFS_CTRL = 8'h00;
  localparam logic [7:0] HFC_OFS_EXC_MASK = 8'h04;
  localparam logic [7:0] HFC_OFS_OPERAND = 8'h08;
  localparam logic [7:0] HFC_OFS_RESULT = 8'h0c;
  localparam logic [7:0] HFC_OFS_STATUS = 8'h10;
  localparam logic [7:0] HFC_OFS_IRQ_EN = 8'h14;
  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int HFC_CTRL_ROUND_LSB = 8;
  localparam int HFC_CTRL_FTZ_BIT = 10;
  localparam int HFC_CTRL_OP_BIT = 16;
  localparam int HFC_IMM_SRC_BIT = 2;
  localparam int HFC_ST_FAULT = 5;
  localparam int HFC_ST_DONE = 6;
  localparam int HFC_ST_W = 7;
  localparam int HFC_FL_INV = 0;
  localparam int HFC_FL_DEN = 1;
  localparam int HFC_FL_UND = 2;
  localparam int HFC_FL_OVF = 3;
  localparam int HFC_FL_PRE = 4;
  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [16:0] HFC_CTRL_RST = 17'h00000;
  localparam logic [4:0] HFC_EXC_MASK_RST = 5'h1f;
  localparam logic [6:0] HFC_IRQ_EN_RST = 7'h00;
  localparam logic [1:0] HFC_RM_NEAREST = 2'h0;
  localparam logic [1:0] HFC_RM_DOWN = 2'h1;
  localparam logic [1:0] HFC_RM_UP = 2'h2;
  localparam logic [1:0] HFC_RM_TRUNC = 2'h3;
  localparam logic [1:0] HFC_RESP_OKAY = 2'h0;
  localparam logic [1:0] HFC_RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Format constants
  // ----------------------------------------------------------------
  localparam logic [7:0] HFC_EXP_BIAS_GAP = 8'h70;
  localparam logic [7:0] HFC_EXP_DEN_BASE = 8'h67;
  localparam int HFC_HALF_EMIN = -14;
  localparam int HFC_HALF_EMAX = 15;
  localparam int HFC_SINGLE_BIAS = 127;
  localparam int HFC_HALF_INF_ENC = 31744;
endpackage : hfc_pkg

/* File: hfc_conv.sv */
// Purpose: Half/single float converter with AXI4-Lite registers.
// Assumes: One clock; a write to the operand register starts one conversion.
// Notes:   Result and flags settle two cycles after the operand write handshake.
`timescale 1ns/1ps
module hfc_conv #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Interrupt
  output logic irq
);
  import hfc_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Byte-lane merge of a bus write into a register word.
  function automatic logic [31:0] hfc_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : hfc_merge

  // Half to single; exact for every input, so only invalid can rise.
  function automatic logic [32:0] hfc_widen(input logic [15:0] h);
    logic [3:0] p;
    logic [22:0] m;
    p = 4'h0;
    for (int i = 0; i < 10; i++)
      if (h[i])
        p = 4'(i);
    m = {h[9:0], 13'h0000} << (4'ha - p);
    if (h[14:10] == 5'h1f)
      hfc_widen = (h[9:0] == 10'h000) ? {1'b0, h[15], 8'hff, 23'h000000}
                                      : {~h[9], h[15], 8'hff, 1'b1, h[8:0], 13'h0000};
    else if (h[14:10] == 5'h00)
      hfc_widen = (h[9:0] == 10'h000) ? {1'b0, h[15], 31'h00000000}
                                      : {1'b0, h[15], 8'({4'h0, p}) + HFC_EXP_DEN_BASE, m};
    else
      hfc_widen = {1'b0, h[15], 8'({3'h0, h[14:10]}) + HFC_EXP_BIAS_GAP, h[9:0], 13'h0000};
  endfunction : hfc_widen

  // Single to half; returns flags above the 16-bit result.
  function automatic logic [20:0] hfc_narrow(input logic [31:0] x, input logic [1:0] rm, input logic um);
    logic s, den, inx, inc, tiny, ovf;
    int ex, sh, enc;
    logic [31:0] sig, kept, rem, halfv;
    logic [15:0] res;
    s = x[31];
    den = (x[30:23] == 8'h00);
    ex = den ? (1 - HFC_SINGLE_BIAS) : (int'(x[30:23]) - HFC_SINGLE_BIAS);
    sig = {8'h00, ~den, x[22:0]};
    sh = (ex >= HFC_HALF_EMIN) ? 13 : (-1 - ex);
    if (sh > 25)
      sh = 25;
    kept = sig >> sh;
    rem = sig & ((32'h1 << sh) - 32'h1);
    halfv = 32'h1 << (sh - 1);
    inx = (rem != 32'h0);
    // Rounding increment per mode.
    case (rm)
      HFC_RM_NEAREST: inc = (rem > halfv) || ((rem == halfv) && kept[0]);
      HFC_RM_DOWN: inc = s && inx;
      HFC_RM_UP: inc = !s && inx;
      default: inc = 1'b0;
    endcase
    tiny = (ex < HFC_HALF_EMIN);
    enc = (ex > HFC_HALF_EMAX) ? HFC_HALF_INF_ENC
        : ((tiny ? 0 : (ex - HFC_HALF_EMIN) * 1024) + int'(kept) + int'(inc));
    ovf = (enc >= HFC_HALF_INF_ENC);
    res = ovf ? {s, 5'h1f, 10'h000} : {s, 15'(enc)};
    hfc_narrow = {ovf || inx, ovf, tiny && (inx || !um), den, 1'b0, res};
    if (x[30:23] == 8'hff)
      hfc_narrow = (x[22:0] == 23'h000000) ? {5'h00, s, 5'h1f, 10'h000}
                 : {4'h0, ~x[22], s, 5'h1f, 1'b1, x[21:13]};
    else if (x[30:0] == 31'h00000000)
      hfc_narrow = {5'h00, s, 15'h0000};
  endfunction : hfc_narrow

  // ----------------------------------------------------------------
  // Bus channel state
  // ----------------------------------------------------------------
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d, ar_addr;
  logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic wr_fire, rd_fire, wr_hit, rd_hit;

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  logic [16:0] ctrl_q, ctrl_d;
  logic [4:0] exc_mask_q, exc_mask_d;
  logic [31:0] operand_q, operand_d, result_q, result_d;
  logic [HFC_ST_W-1:0] status_q, status_d, irq_en_q, irq_en_d;
  logic go_q, go_d, irq_q, irq_d;
  logic [1:0] rmode;
  logic narrow_op;
  logic [32:0] wide_out;
  logic [20:0] narr_out;
  logic [31:0] cv_res;
  logic [4:0] cv_flags;
  logic cv_fault;

  // Address matching used by both channels.
  function automatic logic hfc_mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_W'(HFC_OFS_IRQ_EN));
  endfunction : hfc_mapped

  // Bus handshakes; address and data are taken in either order and the response follows both.
  always_comb
  begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d = w_full_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ar_addr = araddr;
    if (awvalid && awready_q)
    begin
      aw_full_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready_q)
    begin
      w_full_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (bvalid_q && bready)
      bvalid_d = 1'b0;
    wr_fire = aw_full_q && w_full_q && !bvalid_q;
    wr_hit = hfc_mapped(aw_addr_q);
    if (wr_fire)
    begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? HFC_RESP_OKAY : HFC_RESP_SLVERR;
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
    rd_fire = arvalid && arready_q;
    rd_hit = hfc_mapped(ar_addr);
    if (rvalid_q && rready)
      rvalid_d = 1'b0;
    if (rd_fire)
    begin
      rvalid_d = 1'b1;
      rresp_d = rd_hit ? HFC_RESP_OKAY : HFC_RESP_SLVERR;
      case (ADDR_W'(ar_addr))
        ADDR_W'(HFC_OFS_CTRL): rdata_d = {15'h0000, ctrl_q};
        ADDR_W'(HFC_OFS_EXC_MASK): rdata_d = {27'h0000000, exc_mask_q};
        ADDR_W'(HFC_OFS_OPERAND): rdata_d = operand_q;
        ADDR_W'(HFC_OFS_RESULT): rdata_d = result_q;
        ADDR_W'(HFC_OFS_STATUS): rdata_d = {25'h0000000, status_q};
        ADDR_W'(HFC_OFS_IRQ_EN): rdata_d = {25'h0000000, irq_en_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    arready_d = !rvalid_d;
  end

  // Bus channel registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= HFC_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= HFC_RESP_OKAY;
    end
    else
    begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------------------------------
  // Conversion datapath
  // ----------------------------------------------------------------
  // Rounding source and conversion; the flush-to-zero bit is stored but never steers the datapath.
  always_comb
  begin
    narrow_op = ctrl_q[HFC_CTRL_OP_BIT];
    rmode = ctrl_q[HFC_IMM_SRC_BIT] ? ctrl_q[HFC_CTRL_ROUND_LSB +: 2] : ctrl_q[1:0];
    wide_out = hfc_widen(operand_q[15:0]);
    narr_out = hfc_narrow(operand_q, rmode, exc_mask_q[HFC_FL_UND]);
    cv_res = narrow_op ? {16'h0000, narr_out[15:0]} : wide_out[31:0];
    cv_flags = narrow_op ? narr_out[20:16] : {4'h0, wide_out[32]};
    cv_fault = |(cv_flags & ~exc_mask_q);
  end

  // Register writes, sticky flags and interrupt; a hardware set wins over a same-cycle clear.
  always_comb
  begin
    ctrl_d = ctrl_q;
    exc_mask_d = exc_mask_q;
    operand_d = operand_q;
    irq_en_d = irq_en_q;
    result_d = result_q;
    status_d = status_q;
    go_d = 1'b0;
    if (wr_fire && wr_hit)
    begin
      case (ADDR_W'(aw_addr_q))
        ADDR_W'(HFC_OFS_CTRL): ctrl_d = 17'(hfc_merge({15'h0000, ctrl_q}, w_data_q, w_strb_q));
        ADDR_W'(HFC_OFS_EXC_MASK): exc_mask_d = 5'(hfc_merge({27'h0000000, exc_mask_q}, w_data_q, w_strb_q));
        ADDR_W'(HFC_OFS_OPERAND):
        begin
          operand_d = hfc_merge(operand_q, w_data_q, w_strb_q);
          go_d = 1'b1;
        end
        ADDR_W'(HFC_OFS_STATUS): status_d = status_q & ~(w_data_q[HFC_ST_W-1:0] & {HFC_ST_W{w_strb_q[0]}});
        ADDR_W'(HFC_OFS_IRQ_EN): irq_en_d = 7'(hfc_merge({25'h0000000, irq_en_q}, w_data_q, w_strb_q));
        default: ctrl_d = ctrl_q;
      endcase
    end
    if (go_q)
    begin
      // An unmasked exception leaves the previous result in place.
      if (!cv_fault)
        result_d = cv_res;
      status_d = status_d | {1'b1, cv_fault, cv_flags};
    end
    irq_d = |(status_d & irq_en_d);
  end

  // Core registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= HFC_CTRL_RST;
      exc_mask_q <= HFC_EXC_MASK_RST;
      operand_q <= 32'h00000000;
      result_q <= 32'h00000000;
      status_q <= '0;
      irq_en_q <= HFC_IRQ_EN_RST;
      go_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      exc_mask_q <= exc_mask_d;
      operand_q <= operand_d;
      result_q <= result_d;
      status_q <= status_d;
      irq_en_q <= irq_en_d;
      go_q <= go_d;
      irq_q <= irq_d;
    end
  end

  // Outputs straight from flops.
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence narrow_go_s;
    go_q && narrow_op;
  endsequence
  sequence widen_go_s;
    go_q && !narrow_op;
  endsequence

  widen_normal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    widen_go_s and (operand_q[14:10] == 5'h0f) |=> (result_q[30:23] == 8'h7f) && (result_q[22:13] == $past(operand_q[9:0])))
    else $error("widened unit exponent wrong");
  imm_round_a: assert property (@(posedge aclk) disable iff (!aresetn)
    narrow_go_s and (operand_q == 32'h3f801001) and !ctrl_q[2] and (ctrl_q[1:0] == HFC_RM_UP) and exc_mask_q[HFC_FL_PRE]
    |=> result_q[15:0] == 16'h3c01)
    else $error("immediate round up not applied");
  nan_narrow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    narrow_go_s and (operand_q[30:22] == 9'h1fe) and (operand_q[21:0] != 0) and exc_mask_q[0]
    |=> (result_q[14:9] == 6'h3f) && status_q[HFC_FL_INV])
    else $error("signaling NaN not quieted");
  snan_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    go_q && cv_flags[HFC_FL_INV] && !exc_mask_q[HFC_FL_INV] |=> $stable(result_q) && status_q[HFC_ST_FAULT])
    else $error("unmasked invalid wrote a result");
  widen_den_a: assert property (@(posedge aclk) disable iff (!aresetn)
    widen_go_s and !wr_fire and (operand_q[14:10] == 5'h00) |=> $stable(status_q[HFC_FL_DEN]))
    else $error("widening touched denormal flag");
  under_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    narrow_go_s and (operand_q[30:23] == 8'h66) |=> status_q[HFC_FL_UND] && status_q[HFC_ST_DONE])
    else $error("underflow not flagged");
  over_inf_a: assert property (@(posedge aclk) disable iff (!aresetn)
    narrow_go_s and (operand_q[30:23] == 8'h8f) and (exc_mask_q[4:3] == 2'h3)
    |=> (result_q[14:0] == 15'h7c00) && status_q[HFC_FL_OVF] && status_q[HFC_FL_PRE])
    else $error("masked overflow not infinity");
  den_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
    narrow_go_s and (operand_q[30:23] == 8'h00) and (operand_q[22:0] != 0) and exc_mask_q[1] and !exc_mask_q[4]
    |=> (status_q[4:1] & 4'hb) == 4'hb && status_q[HFC_ST_FAULT])
    else $error("denormal exception flags incomplete");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    go_q && cv_fault && irq_en_q[HFC_ST_FAULT] |=> irq_q [*2])
    else $error("interrupt missed after fault");
endmodule : hfc_conv

/* File: hfc_bus_model.sv */
// Purpose: AXI4-Lite master standing in for the processor pipeline.
// Assumes: One clock; requests change only just after a rising edge.
// Notes:   A wait that runs past its bound raises timed_out.
`timescale 1ns/1ps
module hfc_bus_model (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic [2:0] awprot,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // Read channels
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  output logic [2:0] arprot,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Bench status
  output logic timed_out
);
  // Nothing is offered until the first task call.
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, timed_out} = '0;
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    wstrb = 4'hf;
  end

  // One write; address and data are each let go at the edge that takes them.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit aw_ok;
    bit w_ok;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (aw_ok && w_ok && bvalid)
        break;
      if (!aw_ok && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a; // Released lines must not keep looking valid.
      end
      if (!w_ok && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 40)
      timed_out <= 1'b1;
  endtask : wr

  // One read; data and response are taken at the edge that sees rvalid.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    bit ar_ok;
    int n;
    ar_ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (ar_ok && rvalid)
        break;
      if (!ar_ok && arready)
      begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n == 40)
      timed_out <= 1'b1;
  endtask : rd
endmodule : hfc_bus_model

/* File: hfc_conv_tb.sv */
// Purpose: Self-checking bench for the half float converter.
// Assumes: Register map and flag layout of hfc_pkg.
// Notes:   Expected codes are worked out by hand from the two formats.
`timescale 1ns/1ps
module hfc_conv_tb;
  import hfc_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam logic [31:0] NARROW = 32'h00010000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq, timed_out;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [31:0] wdata, rdata, rd_data;
  logic [1:0] bresp, rresp, resp;
  int n_fail = 0;
  int tests_run = 0;

  hfc_conv #(.ADDR_W(8)) hfc_conv_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));
  hfc_bus_model hfc_bus_model_i (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .timed_out(timed_out));

  // 200 MHz clock.
  always #2.5 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Status is cleared before the operand write so every flag seen belongs to this conversion.
  task automatic conv(input logic [31:0] ctrl, input logic [4:0] mask, input logic [31:0] op,
                      input logic [31:0] exp_res, input logic [6:0] exp_st);
    hfc_bus_model_i.wr(HFC_OFS_CTRL, ctrl, resp);
    hfc_bus_model_i.wr(HFC_OFS_EXC_MASK, {27'h0, mask}, resp);
    hfc_bus_model_i.wr(HFC_OFS_STATUS, 32'h0000007f, resp);
    hfc_bus_model_i.wr(HFC_OFS_OPERAND, op, resp);
    chk({30'h0, resp}, {30'h0, HFC_RESP_OKAY});
    hfc_bus_model_i.rd(HFC_OFS_RESULT, rd_data, resp);
    chk(rd_data, exp_res);
    hfc_bus_model_i.rd(HFC_OFS_STATUS, rd_data, resp);
    chk(rd_data, {25'h0, exp_st});
    chk({30'h0, resp}, {30'h0, HFC_RESP_OKAY});
  endtask : conv

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] adr [6] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [31:0] val [6] = '{32'h0, 32'h1f, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++)
    begin
      hfc_bus_model_i.rd(adr[i], rd_data, resp);
      chk(rd_data, val[i]);
    end
    chk({30'h0, resp}, {30'h0, HFC_RESP_SLVERR});
    hfc_bus_model_i.wr(8'h02, 32'hffffffff, resp);
    chk({30'h0, resp}, {30'h0, HFC_RESP_SLVERR});
  endtask : t_regs

  task automatic t_widen;
    conv(32'h0, 5'h1f, 32'h00003c00, 32'h3f800000, 7'h40);
    conv(32'h0, 5'h1f, 32'h00000001, 32'h33800000, 7'h40);
    conv(32'h0, 5'h1f, 32'h00007d00, 32'h7fe00000, 7'h41);
  endtask : t_widen

  // Every code, once from the immediate and once from the global field, with the other source inverted.
  task automatic t_round;
    logic [15:0] pos [4] = '{16'h3c01, 16'h3c00, 16'h3c01, 16'h3c00};
    logic [15:0] neg [4] = '{16'hbc00, 16'hbc01, 16'hbc00, 16'hbc00};
    logic [1:0] c;
    for (int m = 0; m < 4; m++)
    begin
      c = m[1:0];
      conv({15'h0, 1'b1, 6'h0, ~c, 5'h1f, 1'b0, c}, 5'h1f, 32'h3f801001, {16'h0, pos[m]}, 7'h50);
      conv({15'h0, 1'b1, 6'h0, ~c, 5'h1f, 1'b0, c}, 5'h1f, 32'hbf800801, {16'h0, neg[m]}, 7'h50);
      conv({15'h0, 1'b1, 6'h0, c, 5'h00, 1'b1, ~c}, 5'h1f, 32'h3f801001, {16'h0, pos[m]}, 7'h50);
      conv({15'h0, 1'b1, 6'h0, c, 5'h00, 1'b1, ~c}, 5'h1f, 32'hbf800801, {16'h0, neg[m]}, 7'h50);
    end
  endtask : t_round

  // Flush-to-zero is set throughout; tiny results must still come out as subnormals unless they round to zero.
  task automatic t_narrow_exc;
    logic [31:0] op [9] = '{32'h7fc02000, 32'hff802000, 32'h47800000, 32'hc7800000, 32'h477fe000,
                            32'h33000001, 32'h33800000, 32'h38800000, 32'h00000001};
    logic [15:0] res [9] = '{16'h7e01, 16'hfe01, 16'h7c00, 16'hfc00, 16'h7bff,
                             16'h0001, 16'h0001, 16'h0400, 16'h0000};
    logic [6:0] st [9] = '{7'h40, 7'h41, 7'h58, 7'h58, 7'h40, 7'h54, 7'h40, 7'h40, 7'h56};
    for (int i = 0; i < 9; i++)
      conv(NARROW | 32'h00000400, 5'h1f, op[i], {16'h0, res[i]}, st[i]);
  endtask : t_narrow_exc

  // An unmasked fault must leave the previous result in place.
  task automatic t_unmasked;
    conv(NARROW, 5'h1f, 32'h3f800000, 32'h00003c00, 7'h40);
    conv(NARROW, 5'h1e, 32'hff802000, 32'h00003c00, 7'h61);
    conv(NARROW, 5'h1b, 32'h33800000, 32'h00003c00, 7'h64);
    conv(NARROW, 5'h0f, 32'h00000001, 32'h00003c00, 7'h76);
    conv(NARROW, 5'h00, 32'h7fc02000, 32'h00007e01, 7'h40);
  endtask : t_unmasked

  task automatic t_irq;
    hfc_bus_model_i.wr(HFC_OFS_IRQ_EN, 32'h0, resp);
    conv(NARROW, 5'h1f, 32'h3f800000, 32'h00003c00, 7'h40);
    chk({31'h0, irq}, 32'h0);
    hfc_bus_model_i.wr(HFC_OFS_IRQ_EN, 32'h00000040, resp);
    conv(NARROW, 5'h1f, 32'h3f800000, 32'h00003c00, 7'h40);
    chk({31'h0, irq}, 32'h1);
    hfc_bus_model_i.wr(HFC_OFS_STATUS, 32'h00000040, resp);
    hfc_bus_model_i.rd(HFC_OFS_STATUS, rd_data, resp);
    chk({31'h0, irq}, 32'h0);
    // An unmasked fault alone must raise the line when only the fault bit is enabled.
    hfc_bus_model_i.wr(HFC_OFS_IRQ_EN, 32'h00000020, resp);
    conv(NARROW, 5'h1e, 32'hff802000, 32'h00003c00, 7'h61);
    chk({31'h0, irq}, 32'h1);
  endtask : t_irq

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge timed_out)
  begin
    n_fail++;
    test_done();
  end

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_widen();
    t_round();
    t_narrow_exc();
    t_unmasked();
    t_irq();
    test_done();
  end
endmodule : hfc_conv_tb
